// ### hw/ecp_pkg.sv
// constants shared by the event counter waveform generator
package ecp_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [15:0] ECP_IDX_PERIOD_CMP = 16'hFF8C;
	localparam logic [15:0] ECP_IDX_LOW_DATA   = 16'hFF8E;
	localparam logic [15:0] ECP_IDX_EDGE_SEL   = 16'hFF92;
	localparam logic [15:0] ECP_IDX_CNT_CTRL   = 16'hFF94;
	localparam logic [15:0] ECP_IDX_PIN_MODE   = 16'hFFC8;
	localparam logic [15:0] ECP_IDX_PORT_DATA  = 16'hFFC9;
	localparam logic [15:0] ECP_IDX_WAVE_CTRL  = 16'hFFD0;
	localparam logic [15:0] ECP_IDX_IRQ_REQ    = 16'hFFA0;
	localparam logic [15:0] ECP_IDX_IRQ_EN     = 16'hFFA1;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ECP_BIT_GEN_ENABLE = 1;
	localparam int ECP_CLKSEL_LSB     = 1;
	localparam int ECP_BIT_WAVE_TYPE  = 2;
	localparam int ECP_BIT_PIN_MODE   = 0;
	localparam int ECP_BIT_PORT_OUT   = 0;
	localparam int ECP_BIT_PORT_DIR   = 1;
	localparam int ECP_BIT_PORT_IN    = 2;
	localparam int ECP_BIT_IRQ_WAVE   = 0;
	localparam int ECP_BIT_IRQ_EVENT  = 1;

	// ----------------------------------------------------------------
	// widths and reset values
	// ----------------------------------------------------------------
	localparam int          ECP_PRESCALE_W  = 13;
	localparam int          ECP_COUNT_W     = 16;
	localparam logic [15:0] ECP_RST_WORD16  = 16'h0000;
	localparam logic [7:0]  ECP_RST_BYTE    = 8'h00;
	localparam logic [1:0]  ECP_RST_IRQ     = 2'h0;

	// ----------------------------------------------------------------
	// counting clock select codes
	// ----------------------------------------------------------------
	localparam logic [2:0] ECP_CLK_DIV2  = 3'h0;
	localparam logic [2:0] ECP_CLK_DIV8  = 3'h2;
	localparam logic [2:0] ECP_CLK_DIV16 = 3'h3;
	localparam logic [2:0] ECP_CLK_DIV64 = 3'h5;
	localparam logic [2:0] ECP_CLK_MASK64 = 3'h5;

	// prescaler low-bit masks for the tick of each division
	localparam logic [12:0] ECP_MASK_DIV2  = 13'h0001;
	localparam logic [12:0] ECP_MASK_DIV8  = 13'h0007;
	localparam logic [12:0] ECP_MASK_DIV16 = 13'h000F;
	localparam logic [12:0] ECP_MASK_DIV64 = 13'h003F;

endpackage

// ### hw/ecp_prescaler.sv
// free-running prescaler and counting clock tick selector
`timescale 1ns/1ns
module ecp_prescaler
	import ecp_pkg::*;
#(
	parameter int PRESCALE_W = ECP_PRESCALE_W
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [2:0] clk_select,
	output logic            count_tick
);

	logic [PRESCALE_W-1:0] prescaler_counter_reg;
	logic [PRESCALE_W-1:0] prescaler_counter_next;
	logic                  tick_next;
	logic [12:0]           tick_mask;

	// ----------------------------------------------------------------
	// divider selection
	// ----------------------------------------------------------------

	// undefined codes 001, 100 and 110 give no tick
	function automatic logic [12:0] sel_mask(input logic [2:0] sel);
		logic [12:0] m;
		m = 13'h0000;
		if (sel == ECP_CLK_DIV2) begin
			m = ECP_MASK_DIV2;
		end else if (sel == ECP_CLK_DIV8) begin
			m = ECP_MASK_DIV8;
		end else if (sel == ECP_CLK_DIV16) begin
			m = ECP_MASK_DIV16;
		end else if ((sel & ECP_CLK_MASK64) == ECP_CLK_DIV64) begin
			m = ECP_MASK_DIV64;
		end
		return m;
	endfunction

	// next prescaler value and one-cycle tick of the chosen rate
	always_comb begin
		tick_mask              = sel_mask(clk_select);
		prescaler_counter_next = prescaler_counter_reg + 1'b1;
		tick_next              = (tick_mask != 13'h0000) &&
		                         ((prescaler_counter_reg[12:0] & tick_mask) == tick_mask);
	end

	// registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			prescaler_counter_reg <= '0;
			count_tick            <= 1'b0;
		end else if (ce) begin
			prescaler_counter_reg <= prescaler_counter_next;
			count_tick            <= tick_next;
		end
	end

endmodule

// ### hw/ecp_top.sv
// event counter waveform generator with apb registers and pin mux
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns

module ecp_top
	import ecp_pkg::*;
#(
	parameter int ADDR_W  = 18,
	parameter int COUNT_W = ECP_COUNT_W
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              event_input_interrupt,
	input  wire logic              pulse_div_wave,
	input  wire logic              pin_in,
	output logic                   pin_out,
	output logic                   pin_oe,
	output logic                   irq
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	// register file
	logic [15:0]        pwm_period_compare_reg;
	logic [15:0]        pwm_period_compare_next;
	logic [15:0]        pwm_low_time_data_reg;
	logic [15:0]        pwm_low_time_data_next;
	logic [7:0]         input_edge_select_reg;
	logic [7:0]         input_edge_select_next;
	logic [7:0]         counter_control_reg;
	logic [7:0]         counter_control_next;
	logic [7:0]         port_pin_mode_reg;
	logic [7:0]         port_pin_mode_next;
	logic [7:0]         output_waveform_control_reg;
	logic [7:0]         output_waveform_control_next;
	logic [1:0]         port_data_reg;
	logic [1:0]         port_data_next;
	logic [1:0]         interrupt_request_reg;
	logic [1:0]         interrupt_request_next;
	logic [1:0]         interrupt_enable_reg;
	logic [1:0]         interrupt_enable_next;

	// bus answer and interrupt line
	logic [31:0]        prdata_next;
	logic               pready_next;
	logic               pslverr_next;
	logic               irq_next;

	// waveform generator and event input
	logic [COUNT_W-1:0] count_reg;
	logic [COUNT_W-1:0] count_next;
	logic               wave_reg;
	logic               wave_next;
	logic               wave_event;
	logic               event_in_reg;
	logic               event_edge;
	logic               count_tick;
	logic               generator_enable;

	// pin multiplexer
	logic               pin_out_next;
	logic               pin_oe_next;

	// bus decode helpers
	logic               access_first;
	logic               access_done;
	logic               hit_valid;
	logic [31:0]        read_word;
	logic [1:0]         irq_set;
	logic [1:0]         irq_clear;

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] addr_of(input logic [15:0] idx);
		return ADDR_W'({idx, 2'b00});
	endfunction

	// ----------------------------------------------------------------
	// prescaler and counting clock
	// ----------------------------------------------------------------

	// tick of the selected counting clock
	ecp_prescaler #(
		.PRESCALE_W (ECP_PRESCALE_W)
	) u_prescaler (
		.mclk       (mclk),
		.rst        (rst),
		.ce         (ce),
		.clk_select (counter_control_reg[ECP_CLKSEL_LSB+2:ECP_CLKSEL_LSB]),
		.count_tick (count_tick)
	);

	// ----------------------------------------------------------------
	// waveform generator
	// ----------------------------------------------------------------
	assign generator_enable = input_edge_select_reg[ECP_BIT_GEN_ENABLE];

	// period counter, low for data+1 counts then high up to compare
	always_comb begin
		count_next = count_reg;
		wave_next  = wave_reg;
		wave_event = 1'b0;
		if (!generator_enable) begin
			count_next = '0;
			wave_next  = 1'b1;
		end else if (count_tick) begin
			if (count_reg >= COUNT_W'(pwm_period_compare_reg)) begin
				count_next = '0;
				wave_event = 1'b1;
			end else begin
				count_next = count_reg + 1'b1;
			end
			wave_next = (count_next > COUNT_W'(pwm_low_time_data_reg));
		end
	end

	// generator registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			count_reg <= '0;
			wave_reg  <= 1'b1;
		end else if (ce) begin
			count_reg <= count_next;
			wave_reg  <= wave_next;
		end
	end

	// ----------------------------------------------------------------
	// event input edge and interrupt flags
	// ----------------------------------------------------------------

	// event input counts only while the generator is halted
	assign event_edge = event_input_interrupt && !event_in_reg && !generator_enable;

	always_ff @(posedge mclk) begin
		if (rst) begin
			event_in_reg <= 1'b0;
		end else if (ce) begin
			event_in_reg <= event_input_interrupt;
		end
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	assign access_first = psel && penable && !pready;
	assign access_done  = psel && penable && pready;

	// read mux; write-only registers read as zero
	always_comb begin
		read_word = 32'h0000_0000;
		hit_valid = 1'b1;
		if (paddr == addr_of(ECP_IDX_PERIOD_CMP)) begin
			read_word = {16'h0000, pwm_period_compare_reg};
		end else if (paddr == addr_of(ECP_IDX_LOW_DATA)) begin
			read_word = 32'h0000_0000;
		end else if (paddr == addr_of(ECP_IDX_EDGE_SEL)) begin
			read_word = {24'h000000, input_edge_select_reg};
		end else if (paddr == addr_of(ECP_IDX_CNT_CTRL)) begin
			read_word = {24'h000000, counter_control_reg};
		end else if (paddr == addr_of(ECP_IDX_PIN_MODE)) begin
			read_word = {24'h000000, port_pin_mode_reg};
		end else if (paddr == addr_of(ECP_IDX_PORT_DATA)) begin
			read_word = {29'h00000000, pin_in, port_data_reg};
		end else if (paddr == addr_of(ECP_IDX_WAVE_CTRL)) begin
			read_word = 32'h0000_0000;
		end else if (paddr == addr_of(ECP_IDX_IRQ_REQ)) begin
			read_word = {30'h00000000, interrupt_request_reg};
		end else if (paddr == addr_of(ECP_IDX_IRQ_EN)) begin
			read_word = {30'h00000000, interrupt_enable_reg};
		end else begin
			hit_valid = 1'b0;
		end
	end

	// register writes, answer phase and sticky flags
	always_comb begin
		pwm_period_compare_next      = pwm_period_compare_reg;
		pwm_low_time_data_next       = pwm_low_time_data_reg;
		input_edge_select_next       = input_edge_select_reg;
		counter_control_next         = counter_control_reg;
		port_pin_mode_next           = port_pin_mode_reg;
		output_waveform_control_next = output_waveform_control_reg;
		port_data_next               = port_data_reg;
		interrupt_enable_next        = interrupt_enable_reg;
		irq_clear                    = 2'h0;
		pready_next                  = access_first;
		prdata_next                  = access_first ? read_word : 32'h0000_0000;
		pslverr_next                 = access_first && !hit_valid;
		if (access_done && pwrite && hit_valid) begin
			if (paddr == addr_of(ECP_IDX_PERIOD_CMP)) begin
				pwm_period_compare_next = pwdata[15:0];
			end
			if (paddr == addr_of(ECP_IDX_LOW_DATA)) begin
				pwm_low_time_data_next = pwdata[15:0];
			end
			if (paddr == addr_of(ECP_IDX_EDGE_SEL)) begin
				input_edge_select_next = pwdata[7:0];
			end
			if (paddr == addr_of(ECP_IDX_CNT_CTRL)) begin
				counter_control_next = pwdata[7:0];
			end
			if (paddr == addr_of(ECP_IDX_PIN_MODE)) begin
				port_pin_mode_next = pwdata[7:0];
			end
			if (paddr == addr_of(ECP_IDX_WAVE_CTRL)) begin
				output_waveform_control_next = pwdata[7:0];
			end
			if (paddr == addr_of(ECP_IDX_PORT_DATA)) begin
				port_data_next = pwdata[1:0];
			end
			if (paddr == addr_of(ECP_IDX_IRQ_EN)) begin
				interrupt_enable_next = pwdata[1:0];
			end
		end
		// a completed read clears only the bits it returned, so a flag
		// raised while the read is in flight survives for the next read
		if (access_done && !pwrite && paddr == addr_of(ECP_IDX_IRQ_REQ)) begin
			irq_clear = prdata[1:0];
		end
		irq_set                                  = 2'h0;
		irq_set[ECP_BIT_IRQ_WAVE]                = wave_event;
		irq_set[ECP_BIT_IRQ_EVENT]               = event_edge;
		// set wins over a clear in the same cycle
		interrupt_request_next = (interrupt_request_reg & ~irq_clear) | irq_set;
		irq_next = |(interrupt_request_next & interrupt_enable_next);
	end

	// register file and bus answer
	always_ff @(posedge mclk) begin
		if (rst) begin
			pwm_period_compare_reg      <= ECP_RST_WORD16;
			pwm_low_time_data_reg       <= ECP_RST_WORD16;
			input_edge_select_reg       <= ECP_RST_BYTE;
			counter_control_reg         <= ECP_RST_BYTE;
			port_pin_mode_reg           <= ECP_RST_BYTE;
			output_waveform_control_reg <= ECP_RST_BYTE;
			port_data_reg               <= ECP_RST_IRQ;
			interrupt_request_reg       <= ECP_RST_IRQ;
			interrupt_enable_reg        <= ECP_RST_IRQ;
			prdata                      <= 32'h0000_0000;
			pready                      <= 1'b0;
			pslverr                     <= 1'b0;
			irq                         <= 1'b0;
		end else if (ce) begin
			pwm_period_compare_reg      <= pwm_period_compare_next;
			pwm_low_time_data_reg       <= pwm_low_time_data_next;
			input_edge_select_reg       <= input_edge_select_next;
			counter_control_reg         <= counter_control_next;
			port_pin_mode_reg           <= port_pin_mode_next;
			output_waveform_control_reg <= output_waveform_control_next;
			port_data_reg               <= port_data_next;
			interrupt_request_reg       <= interrupt_request_next;
			interrupt_enable_reg        <= interrupt_enable_next;
			prdata                      <= prdata_next;
			pready                      <= pready_next;
			pslverr                     <= pslverr_next;
			irq                         <= irq_next;
		end
	end

	// ----------------------------------------------------------------
	// pin multiplexer
	// ----------------------------------------------------------------

	// waveform pin or general port pin
	always_comb begin
		if (port_pin_mode_reg[ECP_BIT_PIN_MODE]) begin
			pin_oe_next  = 1'b1;
			pin_out_next = output_waveform_control_reg[ECP_BIT_WAVE_TYPE] ?
			               wave_reg : pulse_div_wave;
		end else begin
			pin_oe_next  = port_data_reg[ECP_BIT_PORT_DIR];
			pin_out_next = port_data_reg[ECP_BIT_PORT_OUT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
		end else if (ce) begin
			pin_out <= pin_out_next;
			pin_oe  <= pin_oe_next;
		end
	end

endmodule

// ### tb/ecp_monitor.sv
// checker watching the ports of the waveform generator
`timescale 1ns/1ns
module ecp_monitor
	import ecp_pkg::*;
#(
	parameter int ADDR_W  = 18,
	parameter int COUNT_W = ECP_COUNT_W
) (
	input wire logic              mclk,
	input wire logic              rst,
	input wire logic              ce,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              event_input_interrupt,
	input wire logic              pulse_div_wave,
	input wire logic              pin_in,
	input wire logic              pin_out,
	input wire logic              pin_oe,
	input wire logic              irq
);
	logic [15:0] idx;
	logic        hit;
	logic        wr;
	logic [1:0]  quiet_reg, quiet_next;
	logic [5:0]  shd_reg, shd_next;
	// address decode and completed writes
	assign idx = paddr[ADDR_W-1:2];
	assign hit = paddr[1:0] == 2'h0 && idx inside {ECP_IDX_PERIOD_CMP, ECP_IDX_LOW_DATA,
		ECP_IDX_EDGE_SEL, ECP_IDX_CNT_CTRL, ECP_IDX_PIN_MODE, ECP_IDX_PORT_DATA,
		ECP_IDX_WAVE_CTRL, ECP_IDX_IRQ_REQ, ECP_IDX_IRQ_EN};
	assign wr = psel && penable && pready && pwrite && ce && hit;
	// shadow {dir, enable, type, mode, irq mask} and cycles since last write
	always_comb begin
		shd_next = shd_reg;
		quiet_next = wr ? 2'h0 : quiet_reg + {1'b0, quiet_reg != 2'h3};
		if (wr && idx == ECP_IDX_IRQ_EN) shd_next[1:0] = pwdata[1:0];
		if (wr && idx == ECP_IDX_PIN_MODE) shd_next[2] = pwdata[0];
		if (wr && idx == ECP_IDX_WAVE_CTRL) shd_next[3] = pwdata[2];
		if (wr && idx == ECP_IDX_EDGE_SEL) shd_next[4] = pwdata[1];
		if (wr && idx == ECP_IDX_PORT_DATA) shd_next[5] = pwdata[1];
	end
	// shadow registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			shd_reg <= 6'h00;
			quiet_reg <= 2'h0;
		end else if (ce) begin
			shd_reg <= shd_next;
			quiet_reg <= quiet_next;
		end
	end
	default clocking dc @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_setup;
		psel && !penable && ce;
	endsequence
	sequence s_access;
		psel && penable && ce;
	endsequence
	sequence s_steady;
		shd_reg[4:2] == 3'h7 && quiet_reg == 2'h3;
	endsequence
	a_ready_wait: assert property (s_setup ##1 s_access |=> pready)
		else $error("ready late");
	a_err_unmapped: assert property (pready |-> pslverr == !hit)
		else $error("slave error wrong");
	a_low_min: assert property (s_steady ##0 $fell(pin_out) |=> !pin_out)
		else $error("low part too short");
	a_high_min: assert property (s_steady ##0 $rose(pin_out) |=> pin_out)
		else $error("high part too short");
	a_irq_masked: assert property (shd_reg[1:0] == 2'h0 && quiet_reg == 2'h3 |-> !irq)
		else $error("masked interrupt seen");
	a_idle_high: assert property (shd_reg[4:2] == 3'h3 && quiet_reg == 2'h3 |-> pin_out)
		else $error("halted waveform not high");
	a_div_pass: assert property (shd_reg[3:2] == 2'h1 && quiet_reg == 2'h3 |->
		pin_out == $past(pulse_div_wave)) else $error("division waveform not routed");
	a_pin_drive: assert property (shd_reg[2] && quiet_reg == 2'h3 |-> pin_oe)
		else $error("waveform pin not driven");
	a_pin_release: assert property (shd_reg[5:2] == 4'h0 && quiet_reg == 2'h3 |-> !pin_oe)
		else $error("port pin not released");
endmodule
bind ecp_top ecp_monitor #(.ADDR_W(ADDR_W), .COUNT_W(COUNT_W)) u_mon (.mclk(mclk), .rst(rst),
	.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .irq(irq),
	.event_input_interrupt(event_input_interrupt), .pulse_div_wave(pulse_div_wave),
	.pin_out(pin_out), .pin_oe(pin_oe));

// ### tb/ecp_pin_model.sv
// receiver on the far side of the shared output pin
`timescale 1ns/1ns
module ecp_pin_model (
	input  wire logic  mclk,
	input  wire logic  pin_out,
	input  wire logic  pin_oe,
	input  wire logic  ext_oe,
	input  wire logic  ext_val,
	output logic       pin_level,
	output logic [15:0] low_len,
	output logic [15:0] high_len
);
	logic [15:0] run = 16'h0000;
	logic        last = 1'b1;
	// wire level: block wins, then outside driver, else pull-up
	assign pin_level = pin_oe ? pin_out : (ext_oe ? ext_val : 1'b1);
	// lengths of the last complete low and high runs, in clock cycles
	initial begin
		low_len = 16'h0000;
		high_len = 16'h0000;
	end
	always @(posedge mclk) begin
		if (pin_level != last) begin
			if (last) high_len <= run;
			else low_len <= run;
			run <= 16'h0001;
		end else begin
			run <= run + 16'h0001;
		end
		last <= pin_level;
	end
endmodule

// ### tb/tb_event_counter_pwm_output.sv
// self-checking bench for the event counter waveform generator
`timescale 1ns/1ns
module tb_event_counter_pwm_output
	import ecp_pkg::*;
;
	logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h00000000, prdata, q;
	logic        pready, pslverr, pin_lvl, pin_out, pin_oe, irq, e;
	logic        evt = 1'b0, dwave = 1'b0, ext_oe = 1'b0, ext_val = 1'b0;
	logic [15:0] low_len, high_len, per, low, lfsr = 16'hC596;
	logic [2:0]  codes [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h7};
	logic [15:0] regs [8] = '{ECP_IDX_PERIOD_CMP, ECP_IDX_LOW_DATA, ECP_IDX_EDGE_SEL,
		ECP_IDX_CNT_CTRL, ECP_IDX_PIN_MODE, ECP_IDX_WAVE_CTRL, ECP_IDX_IRQ_REQ, ECP_IDX_IRQ_EN};
	int          bad_count = 0, n_checks = 0, dv;
	ecp_top u_dut (.mclk(mclk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_input_interrupt(evt), .pulse_div_wave(dwave),
		.pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
	ecp_pin_model u_pin (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_oe(ext_oe),
		.ext_val(ext_val), .pin_level(pin_lvl), .low_len(low_len), .high_len(high_len));
	// clock and random division waveform
	initial forever #4 mclk = ~mclk;
	always @(posedge mclk) begin
		lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		dwave <= lfsr[0];
	end
	// counting clock division for a select code
	function automatic int div_of(input logic [2:0] c);
		return (c[0] && c[2]) ? 64 : (c == 3'h3) ? 16 : (c == 3'h2) ? 8 : 2;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// one bus transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge mclk);
		bad_count++;
		$display("Error at %0t: timeout", $time);
		end_of_test;
	end
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		foreach (regs[k]) begin
			apb(1'b0, regs[k], 32'h0);
			chk(q, 32'h0);
		end
		apb(1'b0, 16'h0000, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, ECP_IDX_LOW_DATA, 32'h5);
		apb(1'b0, ECP_IDX_LOW_DATA, 32'h0);
		chk(q, 32'h0);
		apb(1'b1, ECP_IDX_IRQ_EN, 32'h1);
		apb(1'b1, ECP_IDX_PIN_MODE, 32'h1);
		apb(1'b1, ECP_IDX_WAVE_CTRL, 32'h4);
		// each clock select with random period, shortest and longest low part
		foreach (codes[k]) begin
			per = 16'h4 + {12'h0, lfsr[3:0]};
			low = (k == 0) ? 16'h0 : (k == 4) ? per - 16'h1 : {12'h0, lfsr[7:4]} % per;
			dv = div_of(codes[k]);
			apb(1'b1, ECP_IDX_PERIOD_CMP, {16'h0, per});
			apb(1'b1, ECP_IDX_LOW_DATA, {16'h0, low});
			apb(1'b1, ECP_IDX_CNT_CTRL, {28'h0, codes[k], 1'b0});
			apb(1'b1, ECP_IDX_EDGE_SEL, 32'h2);
			repeat ((per + 1) * dv * 3) @(posedge mclk);
			chk(low_len, (low + 1) * dv);
			chk(high_len, (per - low) * dv);
			chk(irq, 1);
			apb(1'b1, ECP_IDX_EDGE_SEL, 32'h0);
			apb(1'b0, ECP_IDX_IRQ_REQ, 32'h0);
			chk(q, 32'h1);
			@(posedge mclk);
			chk(irq, 0);
		end
		apb(1'b1, ECP_IDX_IRQ_EN, 32'h0);
		apb(1'b1, ECP_IDX_EDGE_SEL, 32'h2);
		repeat ((per + 1) * dv * 2) @(posedge mclk);
		chk(irq, 0);
		evt <= 1'b1;
		apb(1'b1, ECP_IDX_EDGE_SEL, 32'h0);
		evt <= 1'b0;
		apb(1'b0, ECP_IDX_IRQ_REQ, 32'h0);
		chk(q, 32'h1);
		evt <= 1'b1;
		repeat (2) @(posedge mclk);
		evt <= 1'b0;
		apb(1'b0, ECP_IDX_IRQ_REQ, 32'h0);
		chk(q, 32'h2);
		apb(1'b1, ECP_IDX_WAVE_CTRL, 32'h0);
		repeat (8) @(posedge mclk);
		apb(1'b1, ECP_IDX_PIN_MODE, 32'h0);
		apb(1'b1, ECP_IDX_PORT_DATA, 32'h3);
		@(posedge mclk);
		chk({pin_oe, pin_out}, 32'h3);
		apb(1'b1, ECP_IDX_PORT_DATA, 32'h0);
		ext_oe <= 1'b1;
		repeat (3) @(posedge mclk);
		apb(1'b0, ECP_IDX_PORT_DATA, 32'h0);
		chk(q, 32'h0);
		ext_oe <= 1'b0;
		repeat (3) @(posedge mclk);
		apb(1'b0, ECP_IDX_PORT_DATA, 32'h0);
		chk(q, 32'h4);
		end_of_test;
	end
endmodule
